// file: include/asrc_pkg.sv
// Contract
// RULE1: Memory floats all data lines in standby when either chip select is inactive.
// RULE2: Full-word read drives data lines 0 to 15.
// RULE3: Lower-lane read drives lines 0 to 7 only.
// RULE4: Upper-lane read drives lines 8 to 15 only.
// RULE5: Selected with output drive off, memory keeps data lines floating.
// RULE6: Write with both lanes stores lines 0 to 15.
// RULE7: Lower-lane write stores lines 0 to 7 only.
// RULE8: Upper-lane write stores lines 8 to 15 only.
// RULE9: Both lane enables high means deselected and floating.
// RULE10: Write window is the overlap of strobe, both selects and a lane.
// RULE11: Host activates all write controls to start; releasing one ends it.
// RULE12: Host holds write data around the edge that ends the window.
// RULE13: Memory floats data during writes with output drive off.
// RULE14: Simultaneous deselect with strobe high leaves outputs floating.
// RULE15: Host never drives data while the memory may still drive them.
// RULE16: Strobe pulse is at least data setup plus strobe-to-float delay.
// RULE17: Address-controlled read keeps device selected with drive and a lane.
// RULE18: Host keeps the write strobe high during every read.
// RULE19: Host presents the address no later than selects and lanes go active.
// RULE20: Write data set up at least 25 ns before the window ends.
// RULE21: Nineteen-bit word address; contents kept across non-write cycles.
package asrc_pkg;

  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;
  localparam int CLK_PERIOD_NS = 20;

  // Timing figures in ns, faster grade
  localparam int T_RC_NS   = 45;
  localparam int T_AA_NS   = 45;
  localparam int T_DOE_NS  = 22;
  localparam int T_HZOE_NS = 18;
  localparam int T_HZWE_NS = 18;
  localparam int T_PWE_NS  = 35;
  localparam int T_SD_NS   = 25;
  localparam int T_AW_NS   = 35;
  localparam int T_WC_NS   = 45;

  // Least times round up to whole cycles
  localparam int RD_CYC    = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_CYC = (T_HZOE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WSTR_NS   = (T_PWE_NS > T_SD_NS + T_HZWE_NS) ? T_PWE_NS
                           : T_SD_NS + T_HZWE_NS;
  localparam int WR_CYC    = (WSTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SD_CYC    = (T_SD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W     = 4;

  typedef enum logic [2:0] {
    ASRC_IDLE,
    ASRC_RD_WAIT,
    ASRC_WR_STROBE,
    ASRC_WR_END,
    ASRC_TURN
  } asrc_state_t;

endpackage : asrc_pkg

// file: test/asrc_host_asserts.sv
`timescale 1ns/1ns
// ----------------------------------------
// Pin protocol checks on the host controller
// ----------------------------------------
module asrc_host_asserts (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  // Observed ports
  input wire logic        req_valid,
  input wire logic        req_write,
  input wire logic [1:0]  req_lanes,
  input wire logic        req_ready,
  input wire logic        rd_valid,
  input wire logic [18:0] mem_addr,
  input wire logic        chip_select_low_active_n,
  input wire logic        chip_select_high_active,
  input wire logic        write_strobe_n,
  input wire logic        output_drive_n,
  input wire logic        upper_byte_lane_n,
  input wire logic        lower_byte_lane_n,
  input wire logic [15:0] data_lines_out,
  input wire logic        data_lines_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic sel;
  assign sel = !chip_select_low_active_n && chip_select_high_active
               && !(upper_byte_lane_n && lower_byte_lane_n);
  sequence rd_take;
    req_valid && req_ready && !req_write && req_lanes != 2'h0;
  endsequence
  sequence strobe_pulse;
    !write_strobe_n [*3] ##1 write_strobe_n;
  endsequence
  read_strobe_a: assert property (!output_drive_n |-> write_strobe_n)
    else $error("strobe low during read");
  strobe_width_a: assert property ($fell(write_strobe_n) |-> strobe_pulse)
    else $error("strobe pulse width wrong");
  write_ctrl_a: assert property (!write_strobe_n |-> sel)
    else $error("strobe low without selects");
  data_setup_a: assert property ($rose(write_strobe_n) |-> data_lines_oe &&
    $stable(data_lines_out) && $past(data_lines_oe, 2)) else $error("write data setup");
  no_contention_a: assert property (data_lines_oe |-> output_drive_n)
    else $error("host drives during output drive");
  read_select_a: assert property (!output_drive_n |-> sel)
    else $error("read without selects");
  addr_hold_a: assert property (sel && $past(sel) |-> $stable(mem_addr))
    else $error("address moved while selected");
  read_answer_a: assert property (rd_take |-> ##4 rd_valid)
    else $error("read answer late");
  write_release_a: assert property ($rose(write_strobe_n) |=> !data_lines_oe && !sel)
    else $error("write not released");
endmodule : asrc_host_asserts

// file: test/asrc_host_tb.sv
`timescale 1ns/1ns
// ----------------------------------------
// Self-checking bench for the host controller
// ----------------------------------------
module asrc_host_tb;
  logic        ref_clk, sys_rst, req_valid, req_write, req_ready, rd_valid;
  logic        cs_n, cs_h, we_n, oe_n, ub_n, lb_n, data_lines_oe;
  logic [18:0] req_addr, mem_addr;
  logic [15:0] req_wdata, rd_data, data_lines_in, data_lines_out, mem_dq, mem_en, pat;
  logic [1:0]  req_lanes;
  logic [31:0] seed;
  logic [15:0] ref_mem [int];
  int          err_total, tests_run;
  asrc_host uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_lanes(req_lanes), .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .mem_addr(mem_addr), .chip_select_low_active_n(cs_n), .chip_select_high_active(cs_h),
    .write_strobe_n(we_n), .output_drive_n(oe_n), .upper_byte_lane_n(ub_n),
    .lower_byte_lane_n(lb_n), .data_lines_in(data_lines_in),
    .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe));
  asrc_mem_model mem (.mem_addr(mem_addr), .chip_select_low_active_n(cs_n),
    .chip_select_high_active(cs_h), .write_strobe_n(we_n), .output_drive_n(oe_n),
    .upper_byte_lane_n(ub_n), .lower_byte_lane_n(lb_n), .data_lines(data_lines_in),
    .mem_dq(mem_dq), .mem_en(mem_en));
  // Floating lines wander so a stale value never passes for read data
  assign data_lines_in = data_lines_oe ? data_lines_out : (mem_dq & mem_en) | (pat & ~mem_en);
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) pat <= pat + 16'h3C01;
  always @(posedge ref_clk) if (data_lines_oe === 1'b1) chk(mem_en, 0);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic op(input logic w, input logic [18:0] a, input logic [15:0] d,
                    input logic [1:0] ln);
    int          n;
    logic [15:0] m;
    m = {{8{ln[1]}}, {8{ln[0]}}};
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      #1 n++;
    end
    {req_valid, req_write, req_addr, req_wdata, req_lanes} = {1'b1, w, a, d, ln};
    @(posedge ref_clk);
    #1 req_valid = 1'b0;
    if (w) begin
      ref_mem[a] = (ref_mem[a] & ~m) | (d & m);
    end else begin
      n = 0;
      while (rd_valid !== 1'b1 && n < 20) begin
        @(posedge ref_clk);
        #1 n++;
      end
      chk(n, asrc_pkg::RD_CYC);
      chk(rd_data, ref_mem[a] & m);
    end
  endtask : op
  task automatic complete_run();
    $display("compares %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  initial begin
    {sys_rst, req_valid, req_write, req_addr, req_wdata, req_lanes} = {1'b1, 39'h0};
    {seed, pat, err_total, tests_run} = {32'd40564, 16'h0000, 64'h0};
    repeat (4) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    for (int i = 0; i < 8; i++) op(1'b1, 19'(i), 16'(rnd()), 2'h3);
    op(1'b1, 19'h7FFFF, 16'hA55A, 2'h3);
    op(1'b0, 19'h7FFFF, 16'h0000, 2'h3);
    $display("test full_word done");
    op(1'b1, 19'h7FFFF, 16'h3CC3, 2'h1);
    op(1'b1, 19'h00000, 16'h9669, 2'h2);
    for (int i = 1; i < 4; i++) op(1'b0, 19'h7FFFF, 16'h0000, 2'(i));
    for (int i = 1; i < 4; i++) op(1'b0, 19'h00000, 16'h0000, 2'(i));
    $display("test byte_lane done");
    {req_valid, req_lanes} = {1'b1, 2'h0};
    repeat (3) @(posedge ref_clk);
    #1 req_valid = 1'b0;
    chk({req_ready, cs_n, we_n}, 3'h7);
    $display("test no_lane done");
    for (int i = 0; i < 60; i++) begin
      op(rnd() % 2 == 0, 19'(rnd() % 8), 16'(rnd()), 2'(rnd() % 3 + 1));
    end
    $display("test random_mix done");
    sys_rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 chk({req_ready, rd_valid, cs_n, we_n, oe_n, data_lines_oe}, 6'h0E);
    sys_rst = 1'b0;
    op(1'b0, 19'h7FFFF, 16'h0000, 2'h3);
    $display("test mid_reset done");
    complete_run();
  end
  initial begin
    #200000;
    err_total++;
    complete_run();
  end
endmodule : asrc_host_tb

bind asrc_host asrc_host_asserts chk_i (.*);

// file: test/asrc_mem_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Memory device on the far side of the pins
// ----------------------------------------
module asrc_mem_model (
  // Memory pins
  input  wire logic [18:0] mem_addr,
  input  wire logic        chip_select_low_active_n,
  input  wire logic        chip_select_high_active,
  input  wire logic        write_strobe_n,
  input  wire logic        output_drive_n,
  input  wire logic        upper_byte_lane_n,
  input  wire logic        lower_byte_lane_n,
  input  wire logic [15:0] data_lines,
  // Drive toward the host
  output logic [15:0]      mem_dq,
  output logic [15:0]      mem_en
);
  logic [15:0] store [0:524287];
  logic        sel, wr, rd;
  logic [15:0] sh_d;
  logic [18:0] sh_a;
  logic [1:0]  sh_l;
  assign sel = !chip_select_low_active_n && chip_select_high_active
               && !(upper_byte_lane_n && lower_byte_lane_n);
  assign wr = sel && !write_strobe_n;
  assign rd = sel && write_strobe_n && !output_drive_n;
  assign mem_en = {{8{rd && !upper_byte_lane_n}}, {8{rd && !lower_byte_lane_n}}};
  assign mem_dq = store[mem_addr];
  // Shadow follows the window so whichever control ends it, the last data counts
  always @* if (wr) begin
    sh_d = data_lines;
    sh_a = mem_addr;
    sh_l = {!upper_byte_lane_n, !lower_byte_lane_n};
  end
  always @(negedge wr) begin
    if (sh_l[0]) store[sh_a][7:0] = sh_d[7:0];
    if (sh_l[1]) store[sh_a][15:8] = sh_d[15:8];
  end
endmodule : asrc_mem_model

// file: verilog/asrc_cycle_timer.sv
`timescale 1ns/1ns
// ----------------------------------------
// Down counter that times bus phases
// ----------------------------------------
module asrc_cycle_timer #(
  parameter int CNT_W = 4
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  // Load and status
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_val,
  output logic                  done
);

  logic [CNT_W-1:0] count;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= '0;
    end else if (load) begin
      count <= load_val;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  // Done ignores load: the sequencer reloads on done, and gating here would close a loop
  assign done = (count == '0);

endmodule : asrc_cycle_timer

// file: verilog/asrc_host.sv
`timescale 1ns/1ns
// ----------------------------------------
// Host controller for the asynchronous memory
// ----------------------------------------
module asrc_host #(
  parameter int RD_CYC    = asrc_pkg::RD_CYC,
  parameter int WR_CYC    = asrc_pkg::WR_CYC,
  parameter int FLOAT_CYC = asrc_pkg::FLOAT_CYC
) (
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        sys_rst,
  // User request
  input  wire logic                        req_valid,
  input  wire logic                        req_write,
  input  wire logic [asrc_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [asrc_pkg::DATA_W-1:0] req_wdata,
  input  wire logic [1:0]                  req_lanes,
  output logic                             req_ready,
  // User answer
  output logic                             rd_valid,
  output logic [asrc_pkg::DATA_W-1:0]      rd_data,
  // Memory pins
  output logic [asrc_pkg::ADDR_W-1:0]      mem_addr,
  output logic                             chip_select_low_active_n,
  output logic                             chip_select_high_active,
  output logic                             write_strobe_n,
  output logic                             output_drive_n,
  output logic                             upper_byte_lane_n,
  output logic                             lower_byte_lane_n,
  input  wire logic [asrc_pkg::DATA_W-1:0] data_lines_in,
  output logic [asrc_pkg::DATA_W-1:0]      data_lines_out,
  output logic                             data_lines_oe
);

  asrc_pkg::asrc_state_t state;
  asrc_pkg::asrc_state_t next_state;
  logic                  is_write;
  logic [1:0]            lanes;
  logic                  tmr_load;
  logic [asrc_pkg::CNT_W-1:0] tmr_val;
  logic                  tmr_done;

  asrc_cycle_timer #(.CNT_W(asrc_pkg::CNT_W)) u_timer (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .load     (tmr_load),
    .load_val (tmr_val),
    .done     (tmr_done)
  );

  // ----------------------------------------
  // Sequencing
  // ----------------------------------------
  always_comb begin
    next_state = state;
    tmr_load   = 1'b0;
    tmr_val    = '0;
    case (state)
      asrc_pkg::ASRC_IDLE: begin
        if (req_valid && req_lanes != 2'b00) begin
          tmr_load = 1'b1;
          if (req_write) begin
            next_state = asrc_pkg::ASRC_WR_STROBE;
            tmr_val    = asrc_pkg::CNT_W'(WR_CYC - 1); // RULE16
          end else begin
            next_state = asrc_pkg::ASRC_RD_WAIT;
            tmr_val    = asrc_pkg::CNT_W'(RD_CYC - 1);
          end
        end
      end
      asrc_pkg::ASRC_RD_WAIT: begin
        if (tmr_done) begin
          next_state = asrc_pkg::ASRC_TURN;
          tmr_load   = 1'b1;
          tmr_val    = asrc_pkg::CNT_W'(FLOAT_CYC - 1); // RULE15
        end
      end
      asrc_pkg::ASRC_WR_STROBE: begin
        if (tmr_done) begin
          next_state = asrc_pkg::ASRC_WR_END;
        end
      end
      asrc_pkg::ASRC_WR_END: begin
        next_state = asrc_pkg::ASRC_IDLE;
      end
      asrc_pkg::ASRC_TURN: begin
        if (tmr_done) begin
          next_state = asrc_pkg::ASRC_IDLE;
        end
      end
      default: begin
        next_state = asrc_pkg::ASRC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= asrc_pkg::ASRC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Request capture; address held for the whole cycle
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_addr       <= '0;
      data_lines_out <= '0;
      is_write       <= 1'b0;
      lanes          <= 2'b00;
    end else if (state == asrc_pkg::ASRC_IDLE && next_state != asrc_pkg::ASRC_IDLE) begin
      mem_addr       <= req_addr; // RULE19 RULE21
      data_lines_out <= req_wdata; // RULE20
      is_write       <= req_write;
      lanes          <= req_lanes;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= (next_state == asrc_pkg::ASRC_IDLE);
    end
  end

  // ----------------------------------------
  // Control pins; all controls go active on the same edge that sets the address; the write strobe releases a cycle before the selects
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      chip_select_low_active_n <= 1'b1;
      chip_select_high_active  <= 1'b0;
      upper_byte_lane_n        <= 1'b1;
      lower_byte_lane_n        <= 1'b1;
      write_strobe_n           <= 1'b1;
      output_drive_n           <= 1'b1;
    end else begin
      case (next_state)
        asrc_pkg::ASRC_RD_WAIT: begin
          chip_select_low_active_n <= 1'b0; // RULE17
          chip_select_high_active  <= 1'b1;
          upper_byte_lane_n        <= (state == asrc_pkg::ASRC_IDLE) ? !req_lanes[1] : !lanes[1];
          lower_byte_lane_n        <= (state == asrc_pkg::ASRC_IDLE) ? !req_lanes[0] : !lanes[0];
          write_strobe_n           <= 1'b1; // RULE18
          output_drive_n           <= 1'b0;
        end
        asrc_pkg::ASRC_WR_STROBE: begin
          // Output drive stays off so the memory never fights the host
          chip_select_low_active_n <= 1'b0; // RULE11
          chip_select_high_active  <= 1'b1;
          upper_byte_lane_n        <= (state == asrc_pkg::ASRC_IDLE) ? !req_lanes[1] : !lanes[1];
          lower_byte_lane_n        <= (state == asrc_pkg::ASRC_IDLE) ? !req_lanes[0] : !lanes[0];
          write_strobe_n           <= 1'b0;
          output_drive_n           <= 1'b1; // RULE13
        end
        asrc_pkg::ASRC_WR_END: begin
          // Strobe ends the window; selects stay one more cycle for data hold
          write_strobe_n <= 1'b1; // RULE12
        end
        default: begin
          chip_select_low_active_n <= 1'b1;
          chip_select_high_active  <= 1'b0;
          upper_byte_lane_n        <= 1'b1;
          lower_byte_lane_n        <= 1'b1;
          write_strobe_n           <= 1'b1;
          output_drive_n           <= 1'b1;
        end
      endcase
    end
  end

  // Data drive spans the strobe and one hold cycle after it rises
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_lines_oe <= 1'b0;
    end else begin
      data_lines_oe <= (next_state == asrc_pkg::ASRC_WR_STROBE) ||
                       (next_state == asrc_pkg::ASRC_WR_END); // RULE15 RULE12
    end
  end

  // ----------------------------------------
  // Read capture; unread lanes return zero
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end else begin
      rd_valid <= 1'b0;
      if (state == asrc_pkg::ASRC_RD_WAIT && tmr_done) begin
        rd_valid <= 1'b1;
        rd_data  <= {lanes[1] ? data_lines_in[15:8] : 8'h00,
                     lanes[0] ? data_lines_in[7:0]  : 8'h00}; // RULE3 RULE4
      end
    end
  end

endmodule : asrc_host
